// file: rtl/rfpm_regs.v
// fault mask and output-one power-good select registers behind an i2c target port
`timescale 1ns/1ns
`include "rfpm_defs.vh"

module rfpm_regs #(
	parameter [6:0] DEV_ADDR = `RFPM_I2C_ADDR,
	parameter [7:0] FAULT_MASK_FIRST_RST = `RFPM_RST_FAULT_MASK_FIRST,
	parameter [4:0] FAULT_MASK_SECOND_RST = `RFPM_RST_FAULT_MASK_SECOND_RAILS,
	parameter [7:0] GOOD_SELECT_FIRST_RST = `RFPM_RST_GOOD_SELECT_FIRST
) (
	input wire ref_clk,
	input wire arst_n,
	input wire scl_in,
	input wire sda_in,
	output reg sda_out,
	output reg sda_oe_n,
	input wire [12:0] rail_fault,
	input wire [7:0] rail_good,
	input wire [7:0] extra_good,
	input wire [7:0] extra_good_ignore,
	output reg shutdown_start,
	output reg general_output_one
);

	localparam S_IDLE = 4'h0;
	localparam S_DEV = 4'h1;
	localparam S_DACK = 4'h2;
	localparam S_PTR = 4'h3;
	localparam S_PACK = 4'h4;
	localparam S_WR = 4'h5;
	localparam S_WACK = 4'h6;
	localparam S_RD = 4'h7;
	localparam S_RACK = 4'h8;
	localparam NSYN = 31;
	// bus lines idle high: a chain reset low would show a false clock edge after reset
	localparam [NSYN-1:0] SYN_IDLE = {{(NSYN-2){1'h0}}, 2'h3};

	// ==================================================
	// input synchronisers: a change counts once stages two and three agree
	reg [NSYN-1:0] syn1_q;
	reg [NSYN-1:0] syn2_q;
	reg [NSYN-1:0] syn3_q;
	reg [NSYN-1:0] filt_q;
	wire [NSYN-1:0] raw_in;
	assign raw_in = {extra_good, rail_good, rail_fault, sda_in, scl_in};

	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			syn1_q <= SYN_IDLE;
			syn2_q <= SYN_IDLE;
			syn3_q <= SYN_IDLE;
			filt_q <= SYN_IDLE;
		end else begin
			syn1_q <= raw_in;
			syn2_q <= syn1_q;
			syn3_q <= syn2_q;
			filt_q <= (syn2_q & syn3_q) | (filt_q & (syn2_q ^ syn3_q));
		end
	end

	wire scl_f = filt_q[0];
	wire sda_f = filt_q[1];
	wire [12:0] fault_f = filt_q[14:2];
	wire [7:0] good_f = filt_q[22:15];
	wire [7:0] extra_f = filt_q[30:23];

	reg scl_prev_q;
	reg sda_prev_q;
	wire scl_rise = scl_f & ~scl_prev_q;
	wire scl_fall = ~scl_f & scl_prev_q;
	wire bus_start = scl_f & scl_prev_q & sda_prev_q & ~sda_f;
	wire bus_stop = scl_f & scl_prev_q & ~sda_prev_q & sda_f;

	// ==================================================
	// registers
	reg [7:0] fault_mask_first_q;
	reg [4:0] fault_mask_second_q;
	reg rsvd_zero_q;
	reg rsvd_one_q;
	reg [7:0] good_select_first_q;

	function [7:0] reg_read;
		input [7:0] ofs;
		input [7:0] m1;
		input [4:0] m2;
		input r0;
		input r1;
		input [7:0] sel;
		begin
			case (ofs)
				`RFPM_OFS_FAULT_MASK_FIRST: reg_read = m1;
				`RFPM_OFS_FAULT_MASK_SECOND: reg_read = {1'h0, r0, r1, m2};
				`RFPM_OFS_GOOD_SELECT_FIRST: reg_read = sel;
				default: reg_read = `RFPM_UNMAPPED_READ;
			endcase
		end
	endfunction

	// ==================================================
	// i2c target
	reg [3:0] state_q;
	reg [3:0] cnt_q;
	reg [7:0] sh_q;
	reg [7:0] ptr_q;
	reg rw_q;
	reg master_ack_q;
	wire [7:0] rd_data = reg_read(ptr_q, fault_mask_first_q, fault_mask_second_q,
		rsvd_zero_q, rsvd_one_q, good_select_first_q);
	wire receiving = (state_q == S_DEV) || (state_q == S_PTR) || (state_q == S_WR);

	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			scl_prev_q <= 1'h1;
			sda_prev_q <= 1'h1;
			state_q <= S_IDLE;
			cnt_q <= 4'h0;
			sh_q <= 8'h00;
			ptr_q <= 8'h00;
			rw_q <= 1'h0;
			master_ack_q <= 1'h0;
			sda_out <= 1'h0;
			sda_oe_n <= 1'h1;
			fault_mask_first_q <= FAULT_MASK_FIRST_RST;
			fault_mask_second_q <= FAULT_MASK_SECOND_RST;
			rsvd_zero_q <= `RFPM_M2_RSVD_ZERO_RST;
			rsvd_one_q <= `RFPM_M2_RSVD_ONE_RST;
			good_select_first_q <= GOOD_SELECT_FIRST_RST;
		end else begin
			scl_prev_q <= scl_f;
			sda_prev_q <= sda_f;
			sda_out <= 1'h0;
			if (bus_start) begin
				state_q <= S_DEV;
				cnt_q <= 4'h0;
				sda_oe_n <= 1'h1;
			end else if (bus_stop) begin
				state_q <= S_IDLE;
				sda_oe_n <= 1'h1;
			end else if (scl_rise) begin
				if (receiving) begin
					sh_q <= {sh_q[6:0], sda_f};
					cnt_q <= cnt_q + 4'h1;
				end else if (state_q == S_RD) begin
					cnt_q <= cnt_q + 4'h1;
				end else if (state_q == S_RACK) begin
					master_ack_q <= ~sda_f;
				end
			end else if (scl_fall) begin
				case (state_q)
					S_DEV: begin
						if (cnt_q == 4'h8) begin
							if (sh_q[7:1] == DEV_ADDR) begin
								rw_q <= sh_q[0];
								sda_oe_n <= 1'h0;
								state_q <= S_DACK;
							end else begin
								state_q <= S_IDLE;
							end
						end
					end
					S_DACK: begin
						cnt_q <= 4'h0;
						if (rw_q) begin
							sh_q <= rd_data;
							sda_oe_n <= rd_data[7];
							ptr_q <= ptr_q + 8'h01;
							state_q <= S_RD;
						end else begin
							sda_oe_n <= 1'h1;
							state_q <= S_PTR;
						end
					end
					S_PTR: begin
						if (cnt_q == 4'h8) begin
							ptr_q <= sh_q;
							sda_oe_n <= 1'h0;
							state_q <= S_PACK;
						end
					end
					S_PACK, S_WACK: begin
						cnt_q <= 4'h0;
						sda_oe_n <= 1'h1;
						state_q <= S_WR;
					end
					S_WR: begin
						if (cnt_q == 4'h8) begin
							case (ptr_q)
								`RFPM_OFS_FAULT_MASK_FIRST: fault_mask_first_q <= sh_q;
								`RFPM_OFS_FAULT_MASK_SECOND: begin
									// top bit is read-only and reads zero
									fault_mask_second_q <= sh_q[`RFPM_M2_RAIL_MSB:0];
									rsvd_zero_q <= sh_q[`RFPM_M2_RSVD_ZERO_BIT];
									rsvd_one_q <= sh_q[`RFPM_M2_RSVD_ONE_BIT];
								end
								`RFPM_OFS_GOOD_SELECT_FIRST: good_select_first_q <= sh_q;
								default: ;
							endcase
							ptr_q <= ptr_q + 8'h01;
							sda_oe_n <= 1'h0;
							state_q <= S_WACK;
						end
					end
					S_RD: begin
						if (cnt_q == 4'h8) begin
							sda_oe_n <= 1'h1;
							state_q <= S_RACK;
						end else begin
							sh_q <= {sh_q[6:0], 1'h0};
							sda_oe_n <= sh_q[6];
						end
					end
					S_RACK: begin
						cnt_q <= 4'h0;
						if (master_ack_q) begin
							sh_q <= rd_data;
							sda_oe_n <= rd_data[7];
							ptr_q <= ptr_q + 8'h01;
							state_q <= S_RD;
						end else begin
							sda_oe_n <= 1'h1;
							state_q <= S_IDLE;
						end
					end
					default: begin
						sda_oe_n <= 1'h1;
						state_q <= S_IDLE;
					end
				endcase
			end
		end
	end

	// ==================================================
	// fault shutdown and power-good tree
	// faults are not latched here: the shutdown sequencer holds its own state
	wire [12:0] fault_ignore = {fault_mask_second_q, fault_mask_first_q};

	always @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			shutdown_start <= 1'h0;
			general_output_one <= 1'h0;
		end else begin
			shutdown_start <= |(fault_f & ~fault_ignore);
			general_output_one <= (&(good_f | good_select_first_q)) & (&(extra_f | extra_good_ignore));
		end
	end

endmodule

// file: rtl/rfpm_defs.vh
// constants for the rail fault mask and output-one power-good select registers
`ifndef RFPM_DEFS_VH
`define RFPM_DEFS_VH

// ==================================================
// register offsets
`define RFPM_OFS_FAULT_MASK_FIRST 8'ha2
`define RFPM_OFS_FAULT_MASK_SECOND 8'ha3
`define RFPM_OFS_GOOD_SELECT_FIRST 8'ha4

// ==================================================
// factory reset defaults, overridable per variant
`define RFPM_RST_FAULT_MASK_FIRST 8'h00
`define RFPM_RST_FAULT_MASK_SECOND_RAILS 5'h00
`define RFPM_RST_GOOD_SELECT_FIRST 8'hff

// ==================================================
// second fault mask fields
`define RFPM_M2_RSVD_RO_BIT 7
`define RFPM_M2_RSVD_ZERO_BIT 6
`define RFPM_M2_RSVD_ONE_BIT 5
`define RFPM_M2_RSVD_ZERO_RST 1'h0
`define RFPM_M2_RSVD_ONE_RST 1'h1
`define RFPM_M2_RAIL_MSB 4

// ==================================================
// bus
// bus address of the target port, value arbitrary
`define RFPM_I2C_ADDR 7'h5e
`define RFPM_UNMAPPED_READ 8'h00

`endif

// file: verif/rfpm_host.sv
// i2c host model for the register port of the mask block
`timescale 1ns/1ns
module rfpm_host (
	input wire ref_clk,
	input wire sda,
	output logic scl,
	output logic sda_o
);
	// ====
	// bus phases
	initial begin
		scl = 1'h1;
		sda_o = 1'h1;
	end
	task automatic t(input int n);
		repeat (n) @(negedge ref_clk);
	endtask
	// 12 clocks a phase keeps clear of the 4 the port filter needs
	task automatic bt(input logic b, output logic r);
		sda_o = b;
		t(12);
		scl = 1'h1;
		t(12);
		r = sda;
		scl = 1'h0;
	endtask
	task automatic st;
		sda_o = 1'h1;
		t(12);
		scl = 1'h1;
		t(12);
		sda_o = 1'h0;
		t(12);
		scl = 1'h0;
	endtask
	task automatic sp;
		sda_o = 1'h0;
		t(12);
		scl = 1'h1;
		t(12);
		sda_o = 1'h1;
		t(12);
	endtask
	task automatic xb(input logic [7:0] d, input logic nak, output logic [7:0] q, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bt(d[i], q[i]);
		bt(nak, r);
		ack = !r;
	endtask
endmodule

// file: verif/rfpm_regs_properties.sv
// pin level checks for the mask register block
`timescale 1ns/1ns
module rfpm_props (
	input wire ref_clk,
	input wire arst_n,
	input wire scl_in,
	input wire sda_in,
	input wire sda_out,
	input wire sda_oe_n,
	input wire [12:0] rail_fault,
	input wire [7:0] rail_good,
	input wire [7:0] extra_good,
	input wire [7:0] extra_good_ignore,
	input wire shutdown_start,
	input wire general_output_one
);
	// ====
	// properties
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	// eight clocks cover input sync, filter and output flop
	sequence calm8;
		(rail_fault == 13'h0) [*8];
	endsequence
	sequence good8;
		(&rail_good && &extra_good) [*8];
	endsequence
	a_sda_only_low: assert property (sda_out == 1'h0)
	else $error("sda drive value not low");
	a_no_fault_quiet: assert property (calm8 |-> !shutdown_start)
	else $error("shutdown without fault");
	a_all_good_out: assert property (good8 |-> general_output_one)
	else $error("output one low with all good");
	a_extra_blocks: assert property (((extra_good_ignore | extra_good) != 8'hff) [*8] |-> !general_output_one)
	else $error("output one high with included extra low");
	a_sda_held_high: assert property (scl_in [*8] ##1 scl_in |-> $stable(sda_oe_n))
	else $error("sda drive changed in clock high");
	a_pull_in_low: assert property ($fell(sda_oe_n) |-> !scl_in)
	else $error("sda pulled in clock high");
	a_release_in_low: assert property ($rose(sda_oe_n) |-> !scl_in)
	else $error("sda released in clock high");
	a_reset_quiet: assert property ($rose(arst_n) |-> sda_oe_n && !shutdown_start && !general_output_one)
	else $error("outputs active after reset");
endmodule
bind rfpm_regs rfpm_props u_props (
	.ref_clk(ref_clk),
	.arst_n(arst_n),
	.scl_in(scl_in),
	.sda_in(sda_in),
	.sda_out(sda_out),
	.sda_oe_n(sda_oe_n),
	.rail_fault(rail_fault),
	.rail_good(rail_good),
	.extra_good(extra_good),
	.extra_good_ignore(extra_good_ignore),
	.shutdown_start(shutdown_start),
	.general_output_one(general_output_one)
);

// file: verif/tb_top.sv
// self-checking bench for the mask and output-one select registers
`timescale 1ns/1ns
module tb_top;
	logic ref_clk = 1'h0;
	logic arst_n = 1'h0;
	logic [12:0] rail_fault = 13'h0;
	logic [7:0] rail_good = 8'h0, extra_good = 8'h0, extra_good_ignore = 8'hff, m1, m2, sel, got;
	wire scl_in, sda_in, sda_out, sda_oe_n, shutdown_start, general_output_one, h_sda;
	logic a;
	int error_cnt = 0, total_checks = 0, cyc = 0;
	logic [7:0] qe[$];
	string qn[$];
	event ev;
	rfpm_regs dut (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.scl_in(scl_in),
		.sda_in(sda_in),
		.sda_out(sda_out),
		.sda_oe_n(sda_oe_n),
		.rail_fault(rail_fault),
		.rail_good(rail_good),
		.extra_good(extra_good),
		.extra_good_ignore(extra_good_ignore),
		.shutdown_start(shutdown_start),
		.general_output_one(general_output_one)
	);
	rfpm_host host (.ref_clk(ref_clk), .sda(sda_in), .scl(scl_in), .sda_o(h_sda));
	// pulled-up wire: low when either side pulls
	assign sda_in = h_sda & (sda_oe_n | sda_out);
	initial forever #50 ref_clk = ~ref_clk;
	// ====
	// checking
	task automatic test_done;
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 40000) begin
			error_cnt++;
			test_done;
		end
	end
	always @(ev) begin
		total_checks++;
		if (got !== qe[0])
			$display("mismatch %s exp %h got %h", qn[0], qe[0], got);
		if (got !== qe[0])
			error_cnt++;
		void'(qe.pop_front());
		void'(qn.pop_front());
	end
	task automatic note(input string n, input logic [7:0] e, g);
		qn.push_back(n);
		qe.push_back(e);
		got = g;
		->ev;
		// next stimulus stays on a falling edge
		@(negedge ref_clk);
	endtask
	task automatic wb(input logic [7:0] d, input logic e);
		logic [7:0] q;
		host.xb(d, 1'h1, q, a);
		note("ack", {7'h0, e}, {7'h0, a});
	endtask
	task automatic wr(input logic [23:0] d);
		host.st();
		wb(8'hbc, 1'h1);
		wb(8'ha2, 1'h1);
		for (int i = 0; i < 3; i++)
			wb(d[23-8*i -: 8], 1'h1);
		host.sp();
	endtask
	task automatic rd(input logic [7:0] o, input logic [23:0] e);
		logic [7:0] q;
		host.st();
		wb(8'hbc, 1'h1);
		wb(o, 1'h1);
		host.st();
		wb(8'hbd, 1'h1);
		for (int i = 0; i < 3; i++) begin
			host.xb(8'hff, i == 2, q, a);
			note("read", e[23-8*i -: 8], q);
		end
		host.sp();
	endtask
	task automatic pins;
		repeat (10) @(negedge ref_clk);
		note("shutdown", {7'h0, |(rail_fault & ~{m2[4:0], m1})}, {7'h0, shutdown_start});
		note("good", {7'h0, &(rail_good | sel) & &(extra_good | extra_good_ignore)}, {7'h0, general_output_one});
	endtask
	// ====
	// tests
	initial begin
		void'($urandom(32'hfbb45661));
		repeat (5) @(negedge ref_clk);
		arst_n = 1'h1;
		repeat (10) @(negedge ref_clk);
		rd(8'ha2, 24'h0020ff);
		host.st();
		wb(8'h5a, 1'h0);
		host.sp();
		rd(8'ha5, 24'h0);
		$display("test reset and bus done");
		for (int i = 0; i < 8; i++) begin
			m1 = 8'($urandom);
			m2 = {3'h5, 5'($urandom)};
			sel = 8'($urandom);
			wr({m1, m2, sel});
			rd(8'ha2, {m1, 3'h1, m2[4:0], sel});
			rail_fault = 13'h1 << ($urandom % 13);
			rail_good = 8'($urandom) | 8'($urandom);
			extra_good = 8'($urandom) | 8'($urandom);
			extra_good_ignore = i[0] ? 8'hff : 8'($urandom);
			pins;
		end
		rail_fault = 13'h0;
		rail_good = 8'hff;
		extra_good = 8'hff;
		pins;
		$display("test pins done");
		test_done;
	end
endmodule
